/* File: pkg/fcsl_map.vh */
// Constants for the flash command and status host controller
`ifndef FCSL_MAP_VH
`define FCSL_MAP_VH
// =====================================
// Command codes
`define FCSL_CMD_READ_ARRAY 8'hff
`define FCSL_CMD_READ_STATUS 8'h70
`define FCSL_CMD_CLEAR_STATUS 8'h50
`define FCSL_CMD_ERASE_SETUP 8'h20
`define FCSL_CMD_CONFIRM 8'hd0
`define FCSL_CMD_PROGRAM_SETUP 8'h40
`define FCSL_CMD_BUFFER_SETUP 8'he8
`define FCSL_CMD_SUSPEND 8'hb0
// =====================================
// Operation codes on op_code_i
`define FCSL_OP_READ_STATUS 3'h0
`define FCSL_OP_CLEAR_STATUS 3'h1
`define FCSL_OP_ERASE 3'h2
`define FCSL_OP_PROGRAM 3'h3
`define FCSL_OP_BUFFER 3'h4
`define FCSL_OP_SUSPEND 3'h5
`define FCSL_OP_RESUME 3'h6
`define FCSL_OP_READ_ARRAY 3'h7
// =====================================
// Status bit positions
`define FCSL_SR_READY 7
`define FCSL_SR_ERASE_SUSP 6
`define FCSL_SR_ERASE_ERR 5
`define FCSL_SR_PROG_ERR 4
`define FCSL_SR_LOW_VOLT 3
`define FCSL_SR_PROG_SUSP 2
`define FCSL_SR_LOCKED 1
`define FCSL_XSR_AVAIL 7
// =====================================
// Bus timing in ns and cycles at 10 ns
`define FCSL_CLK_NS 10
`define FCSL_T_WRITE_NS 70
`define FCSL_T_READ_NS 120
`define FCSL_T_HIGH_NS 30
`define FCSL_WRITE_CYC ((`FCSL_T_WRITE_NS + `FCSL_CLK_NS - 1) / `FCSL_CLK_NS)
`define FCSL_READ_CYC ((`FCSL_T_READ_NS + `FCSL_CLK_NS - 1) / `FCSL_CLK_NS)
`define FCSL_HIGH_CYC ((`FCSL_T_HIGH_NS + `FCSL_CLK_NS - 1) / `FCSL_CLK_NS)
`endif

/* File: src/fcsl_bus_cycle.v */
// One asynchronous flash bus cycle, write or read
`timescale 1ns/1ns
`include "fcsl_map.vh"
module fcsl_bus_cycle (
	input wire clk_sys_i,
	input wire rst_b_i,
	input wire start_i,
	input wire write_i,
	input wire [22:0] addr_i,
	input wire [15:0] wdata_i,
	output wire busy_o,
	output reg done_o,
	output reg [15:0] rdata_o,
	output reg chip_select_0_b_o,
	output reg oe_b_o,
	output reg we_b_o,
	output reg [22:0] addr_o,
	output reg [15:0] dq_o,
	output reg dq_oe_o,
	input wire [15:0] dq_i
);
	localparam ST_IDLE = 2'h0;
	localparam ST_STROBE = 2'h1;
	localparam ST_HIGH = 2'h2;
	// Counter loads, cut to the counter width on use
	localparam [31:0] WRITE_LOAD = `FCSL_WRITE_CYC + 2;
	localparam [31:0] READ_LOAD = `FCSL_READ_CYC + 3;
	localparam [31:0] HIGH_LOAD = `FCSL_HIGH_CYC;
	reg [1:0] state_reg;
	reg [3:0] count_reg;
	reg write_reg;
	// Three-stage sampler on the returning data
	reg [15:0] dq_s1_reg, dq_s2_reg, dq_s3_reg;
	// Per-bit filtered data; a bit changes once stages 2 and 3 agree
	reg [15:0] dq_filt_reg;
	assign busy_o = (state_reg != ST_IDLE);
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dq_s1_reg <= 16'h0000;
			dq_s2_reg <= 16'h0000;
			dq_s3_reg <= 16'h0000;
			dq_filt_reg <= 16'h0000;
		end else begin
			dq_s1_reg <= dq_i;
			dq_s2_reg <= dq_s1_reg;
			dq_s3_reg <= dq_s2_reg;
			dq_filt_reg <= (dq_s3_reg & ~(dq_s2_reg ^ dq_s3_reg)) |
				(dq_filt_reg & (dq_s2_reg ^ dq_s3_reg));
		end
	end
	// =====================================
	// Strobe sequencer; strobes released between cycles
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_IDLE;
			count_reg <= 4'h0;
			write_reg <= 1'b0;
			done_o <= 1'b0;
			rdata_o <= 16'h0000;
			chip_select_0_b_o <= 1'b1;
			oe_b_o <= 1'b1;
			we_b_o <= 1'b1;
			addr_o <= 23'h000000;
			dq_o <= 16'h0000;
			dq_oe_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				if (start_i) begin
					write_reg <= write_i;
					addr_o <= addr_i;
					dq_o <= wdata_i;
					dq_oe_o <= write_i;
					chip_select_0_b_o <= 1'b0;
					oe_b_o <= write_i;
					we_b_o <= ~write_i;
					count_reg <= write_i ? WRITE_LOAD[3:0] : READ_LOAD[3:0];
					state_reg <= ST_STROBE;
				end
			end
			ST_STROBE: begin
				if (count_reg == 4'h0) begin
					// Status latched at strobe fall; release so next read updates
					if (!write_reg)
						rdata_o <= dq_filt_reg;
					chip_select_0_b_o <= 1'b1;
					oe_b_o <= 1'b1;
					we_b_o <= 1'b1;
					dq_oe_o <= 1'b0;
					count_reg <= HIGH_LOAD[3:0];
					state_reg <= ST_HIGH;
				end else begin
					count_reg <= count_reg - 4'h1;
				end
			end
			default: begin
				if (count_reg == 4'h0) begin
					done_o <= 1'b1;
					state_reg <= ST_IDLE;
				end else begin
					count_reg <= count_reg - 4'h1;
				end
			end
			endcase
		end
	end
endmodule

/* File: src/fcsl_host.v */
// Host controller issuing flash command sequences and polling status
`timescale 1ns/1ns
`include "fcsl_map.vh"
module fcsl_host (
	input wire clk_sys_i,
	input wire rst_b_i,
	input wire op_valid_i,
	output wire op_ready_o,
	input wire [2:0] op_code_i,
	input wire [22:0] op_addr_i,
	input wire [15:0] op_data_i,
	input wire [4:0] buf_count_i,
	output wire buf_data_ready_o,
	input wire buf_data_valid_i,
	input wire [22:0] buf_addr_i,
	input wire [15:0] buf_data_i,
	output reg done_o,
	output reg [7:0] device_status_o,
	output reg [7:0] buffer_status_o,
	output reg err_sequence_o,
	output reg err_program_o,
	output reg err_erase_o,
	output reg err_low_voltage_o,
	output reg err_locked_o,
	output reg refused_o,
	output reg erase_suspended_o,
	output reg program_suspended_o,
	output wire ready_o,
	output wire chip_select_0_b_o,
	output wire oe_b_o,
	output wire we_b_o,
	output wire [22:0] addr_o,
	output wire [15:0] dq_o,
	output wire dq_oe_o,
	input wire [15:0] dq_i,
	input wire status_output_pin_i
);
	localparam ST_IDLE = 4'h0;
	localparam ST_CMD1 = 4'h1;
	localparam ST_CMD2 = 4'h2;
	localparam ST_POLL = 4'h3;
	localparam ST_BUF_POLL = 4'h4;
	localparam ST_BUF_COUNT = 4'h5;
	localparam ST_BUF_DATA = 4'h6;
	localparam ST_BUF_CONF = 4'h7;
	localparam ST_FINISH = 4'h8;
	localparam ST_WAIT = 4'h9;
	reg [3:0] state_reg, ret_reg;
	reg [2:0] op_reg;
	reg [22:0] addr_reg;
	reg [15:0] data_reg;
	reg [4:0] left_reg;
	reg es_reg, ps_reg;
	reg start_reg, write_reg;
	reg [22:0] cyc_addr_reg;
	reg [15:0] cyc_data_reg;
	wire cyc_busy;
	wire cyc_done;
	wire [15:0] cyc_rdata;
	// Status pin through three stages; change once stages 2 and 3 agree
	reg sts_s1_reg, sts_s2_reg, sts_s3_reg, sts_reg;
	// Low byte of status with reserved bits masked
	function [7:0] fcsl_mask_sr;
		input [15:0] raw;
		fcsl_mask_sr = {raw[7:1], 1'b0};
	endfunction
	fcsl_bus_cycle u_cycle (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.start_i(start_reg),
		.write_i(write_reg),
		.addr_i(cyc_addr_reg),
		.wdata_i(cyc_data_reg),
		.busy_o(cyc_busy),
		.done_o(cyc_done),
		.rdata_o(cyc_rdata),
		.chip_select_0_b_o(chip_select_0_b_o),
		.oe_b_o(oe_b_o),
		.we_b_o(we_b_o),
		.addr_o(addr_o),
		.dq_o(dq_o),
		.dq_oe_o(dq_oe_o),
		.dq_i(dq_i)
	);
	assign op_ready_o = (state_reg == ST_IDLE);
	assign buf_data_ready_o = (state_reg == ST_BUF_DATA) && !cyc_busy && !start_reg;
	assign ready_o = sts_reg;
	// =====================================
	// Status pin sampler
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sts_s1_reg <= 1'b0;
			sts_s2_reg <= 1'b0;
			sts_s3_reg <= 1'b0;
			sts_reg <= 1'b0;
		end else begin
			sts_s1_reg <= status_output_pin_i;
			sts_s2_reg <= sts_s1_reg;
			sts_s3_reg <= sts_s2_reg;
			if (sts_s2_reg == sts_s3_reg)
				sts_reg <= sts_s3_reg;
		end
	end
	// =====================================
	// Command sequencer
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_IDLE;
			ret_reg <= ST_IDLE;
			op_reg <= 3'h0;
			addr_reg <= 23'h000000;
			data_reg <= 16'h0000;
			left_reg <= 5'h00;
			es_reg <= 1'b0;
			ps_reg <= 1'b0;
			start_reg <= 1'b0;
			write_reg <= 1'b0;
			cyc_addr_reg <= 23'h000000;
			cyc_data_reg <= 16'h0000;
			done_o <= 1'b0;
			device_status_o <= 8'h00;
			buffer_status_o <= 8'h00;
			err_sequence_o <= 1'b0;
			err_program_o <= 1'b0;
			err_erase_o <= 1'b0;
			err_low_voltage_o <= 1'b0;
			err_locked_o <= 1'b0;
			refused_o <= 1'b0;
			erase_suspended_o <= 1'b0;
			program_suspended_o <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			done_o <= 1'b0;
			refused_o <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				if (op_valid_i) begin
					op_reg <= op_code_i;
					addr_reg <= op_addr_i;
					data_reg <= op_data_i;
					left_reg <= buf_count_i;
					cyc_addr_reg <= op_addr_i;
					write_reg <= 1'b1;
					state_reg <= ST_CMD1;
					start_reg <= 1'b1;
					case (op_code_i)
					`FCSL_OP_READ_STATUS: cyc_data_reg <= {8'h00, `FCSL_CMD_READ_STATUS};
					`FCSL_OP_CLEAR_STATUS: cyc_data_reg <= {8'h00, `FCSL_CMD_CLEAR_STATUS};
					`FCSL_OP_ERASE: cyc_data_reg <= {8'h00, `FCSL_CMD_ERASE_SETUP};
					`FCSL_OP_PROGRAM: cyc_data_reg <= {8'h00, `FCSL_CMD_PROGRAM_SETUP};
					`FCSL_OP_BUFFER: cyc_data_reg <= {8'h00, `FCSL_CMD_BUFFER_SETUP};
					`FCSL_OP_SUSPEND: cyc_data_reg <= {8'h00, `FCSL_CMD_SUSPEND};
					`FCSL_OP_RESUME: cyc_data_reg <= {8'h00, `FCSL_CMD_CONFIRM};
					default: cyc_data_reg <= {8'h00, `FCSL_CMD_READ_ARRAY};
					endcase
					// Erase and buffer setup not offered while suspended
					if ((es_reg || ps_reg) && (op_code_i == `FCSL_OP_ERASE ||
						op_code_i == `FCSL_OP_BUFFER || op_code_i == `FCSL_OP_SUSPEND)) begin
						refused_o <= 1'b1;
						start_reg <= 1'b0;
						done_o <= 1'b1;
						state_reg <= ST_IDLE;
					end else if (op_code_i == `FCSL_OP_BUFFER &&
						(device_status_o[`FCSL_SR_PROG_ERR] ||
						device_status_o[`FCSL_SR_ERASE_ERR])) begin
						refused_o <= 1'b1;
						start_reg <= 1'b0;
						done_o <= 1'b1;
						state_reg <= ST_IDLE;
					end else if (op_code_i == `FCSL_OP_RESUME && !es_reg && !ps_reg) begin
						refused_o <= 1'b1;
						start_reg <= 1'b0;
						done_o <= 1'b1;
						state_reg <= ST_IDLE;
					end else if (op_code_i == `FCSL_OP_PROGRAM && ps_reg) begin
						refused_o <= 1'b1;
						start_reg <= 1'b0;
						done_o <= 1'b1;
						state_reg <= ST_IDLE;
					end
				end
			end
			ST_CMD1: begin
				if (cyc_done) begin
					if (op_reg == `FCSL_OP_ERASE) begin
						cyc_data_reg <= {8'h00, `FCSL_CMD_CONFIRM};
						state_reg <= ST_CMD2;
						start_reg <= 1'b1;
					end else if (op_reg == `FCSL_OP_PROGRAM) begin
						cyc_data_reg <= data_reg;
						state_reg <= ST_CMD2;
						start_reg <= 1'b1;
					end else if (op_reg == `FCSL_OP_BUFFER) begin
						write_reg <= 1'b0;
						state_reg <= ST_BUF_POLL;
						start_reg <= 1'b1;
					end else if (op_reg == `FCSL_OP_CLEAR_STATUS) begin
						device_status_o <= 8'h80;
						err_sequence_o <= 1'b0;
						err_program_o <= 1'b0;
						err_erase_o <= 1'b0;
						err_low_voltage_o <= 1'b0;
						err_locked_o <= 1'b0;
						state_reg <= ST_FINISH;
					end else if (op_reg == `FCSL_OP_READ_ARRAY) begin
						state_reg <= ST_FINISH;
					end else begin
						state_reg <= ST_CMD2;
					end
				end
			end
			ST_CMD2: begin
				// Poll status after every command except clear status and read array; device is in status mode
				if (!cyc_busy && !start_reg) begin
					write_reg <= 1'b0;
					start_reg <= 1'b1;
					state_reg <= ST_POLL;
				end
			end
			ST_POLL: begin
				if (cyc_done) begin
					device_status_o <= fcsl_mask_sr(cyc_rdata);
					// Only bit 7 tells completion; low bits invalid while busy
					if (!cyc_rdata[`FCSL_SR_READY]) begin
						state_reg <= ST_WAIT;
						ret_reg <= ST_POLL;
					end else begin
						// Error decode
						err_sequence_o <= cyc_rdata[`FCSL_SR_ERASE_ERR] &
							cyc_rdata[`FCSL_SR_PROG_ERR];
						err_erase_o <= cyc_rdata[`FCSL_SR_ERASE_ERR];
						err_program_o <= cyc_rdata[`FCSL_SR_PROG_ERR];
						err_low_voltage_o <= cyc_rdata[`FCSL_SR_LOW_VOLT];
						err_locked_o <= cyc_rdata[`FCSL_SR_LOCKED];
						// Suspend state from bits 6 and 2
						if (op_reg == `FCSL_OP_SUSPEND || op_reg == `FCSL_OP_RESUME) begin
							es_reg <= cyc_rdata[`FCSL_SR_ERASE_SUSP];
							ps_reg <= cyc_rdata[`FCSL_SR_PROG_SUSP];
							erase_suspended_o <= cyc_rdata[`FCSL_SR_ERASE_SUSP];
							program_suspended_o <= cyc_rdata[`FCSL_SR_PROG_SUSP];
						end
						state_reg <= ST_FINISH;
					end
				end
			end
			ST_WAIT: begin
				// Strobes high between reads so status relatches
				if (!cyc_busy && !start_reg) begin
					start_reg <= 1'b1;
					state_reg <= ret_reg;
				end
			end
			ST_BUF_POLL: begin
				if (cyc_done) begin
					buffer_status_o <= {cyc_rdata[`FCSL_XSR_AVAIL], 7'h00};
					if (cyc_rdata[`FCSL_XSR_AVAIL]) begin
						write_reg <= 1'b1;
						cyc_addr_reg <= addr_reg;
						cyc_data_reg <= {11'h000, left_reg - 5'h01};
						start_reg <= 1'b1;
						state_reg <= ST_BUF_COUNT;
					end else begin
						cyc_data_reg <= {8'h00, `FCSL_CMD_BUFFER_SETUP};
						write_reg <= 1'b1;
						start_reg <= 1'b1;
						state_reg <= ST_CMD1;
					end
				end
			end
			ST_BUF_COUNT: begin
				if (cyc_done)
					state_reg <= ST_BUF_DATA;
			end
			ST_BUF_DATA: begin
				if (buf_data_valid_i && buf_data_ready_o) begin
					cyc_addr_reg <= buf_addr_i;
					cyc_data_reg <= buf_data_i;
					start_reg <= 1'b1;
					left_reg <= left_reg - 5'h01;
					if (left_reg == 5'h01)
						state_reg <= ST_BUF_CONF;
				end
			end
			ST_BUF_CONF: begin
				if (!cyc_busy && !start_reg) begin
					cyc_addr_reg <= addr_reg;
					cyc_data_reg <= {8'h00, `FCSL_CMD_CONFIRM};
					start_reg <= 1'b1;
					state_reg <= ST_CMD2;
				end
			end
			default: begin
				done_o <= 1'b1;
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end
endmodule

/* File: verif/fcsl_host_props.sv */
// Concurrent checks on the flash host controller ports
`timescale 1ns/1ns
module fcsl_host_props (
	input wire clk_sys_i,
	input wire rst_b_i,
	input wire op_valid_i,
	input wire op_ready_o,
	input wire done_o,
	input wire refused_o,
	input wire [7:0] device_status_o,
	input wire [7:0] buffer_status_o,
	input wire chip_select_0_b_o,
	input wire oe_b_o,
	input wire we_b_o,
	input wire [22:0] addr_o,
	input wire [15:0] dq_o,
	input wire dq_oe_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	// ==========
	// Handshake and result
	done_pulse_a: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
	refuse_done_a: assert property (refused_o |-> done_o) else $error("refusal without done");
	op_taken_a: assert property (op_valid_i && op_ready_o |=> !op_ready_o || refused_o) else $error("ready after take");
	ready_bit_a: assert property (done_o && !refused_o |-> device_status_o[7]) else $error("done while busy");
	status_mask_a: assert property (device_status_o[0] == 1'b0 && buffer_status_o[6:0] == 7'h00) else $error("reserved bits kept");
	// ==========
	// Flash bus strobes
	strobe_excl_a: assert property (!(!we_b_o && !oe_b_o)) else $error("write and read strobes together");
	write_drive_a: assert property (!we_b_o |-> dq_oe_o && !chip_select_0_b_o) else $error("write without drive");
	write_hold_a: assert property ($fell(we_b_o) |=> (!we_b_o && $stable(dq_o) && $stable(addr_o))[*6]) else $error("write cycle short");
	oe_recover_a: assert property ($rose(oe_b_o) |-> oe_b_o[*3]) else $error("read strobe gap short");
	// ==========
	// Main scenarios
	cov_refuse: cover property (done_o && refused_o);
	cov_error: cover property (done_o && device_status_o[4]);
	cov_write: cover property ($fell(we_b_o));
endmodule
bind fcsl_host fcsl_host_props u_props (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
	.op_valid_i(op_valid_i), .op_ready_o(op_ready_o), .done_o(done_o), .refused_o(refused_o),
	.device_status_o(device_status_o), .buffer_status_o(buffer_status_o),
	.chip_select_0_b_o(chip_select_0_b_o), .oe_b_o(oe_b_o), .we_b_o(we_b_o),
	.addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o));

/* File: verif/fcsl_flash_model.sv */
// Behavioural flash device answering command writes and status reads
`timescale 1ns/1ns
module fcsl_flash_model #(
	parameter BUSY_CYC = 30
) (
	input wire clk_sys_i,
	input wire chip_select_0_b_i,
	input wire oe_b_i,
	input wire we_b_i,
	input wire [15:0] dq_i,
	output wire [15:0] dq_o,
	output wire status_output_pin_o,
	input wire supply_low_i,
	input wire block_locked_i
);
	reg [7:0] sr = 8'h00;
	reg [7:0] lat = 8'h80;
	reg [7:0] c;
	reg [6:0] tick = 7'h00;
	reg [1:0] mode = 2'd0;
	reg [2:0] ph = 3'd0;
	reg [5:0] left = 6'd0;
	reg susp = 1'b0;
	reg kind = 1'b0;
	reg we_q = 1'b1;
	reg oe_q = 1'b1;
	reg cs_q = 1'b1;
	// Last word seen on the bus while the write strobe was low
	reg [15:0] wd = 16'h0000;
	integer busy = 0;
	wire rdy = (busy == 0) || susp;
	wire drive = !chip_select_0_b_i && !oe_b_i;
	// Level pin, high when ready or suspended
	assign status_output_pin_o = rdy;
	// Busy hides bits 6:0 behind a moving pattern; released bus shows inverse
	assign dq_o = drive ? {8'h00, lat[7] ? lat : {1'b0, tick}} : ~{8'h00, lat};
	// Launch of an erase or program
	task start(input er);
		begin
			mode = 2'd1;
			kind = er;
			if (supply_low_i) begin
				sr[3] = 1'b1;
				sr[er ? 5 : 4] = 1'b1;
			end else if (block_locked_i) begin
				sr[1] = 1'b1;
				sr[er ? 5 : 4] = 1'b1;
			end else
				busy = BUSY_CYC;
		end
	endtask
	// Command decode on write strobe rise, status latch on read strobe fall
	always @(posedge clk_sys_i) begin
		tick = tick + 7'h1;
		if (busy > 0 && !susp)
			busy = busy - 1;
		if (drive && oe_q)
			lat = (mode == 2'd0) ? 8'hff : (mode == 2'd2) ? 8'h80 : {rdy, sr[6:1], 1'b0};
		if (we_b_i && !we_q && !cs_q) begin
			c = wd[7:0];
			case (ph)
			3'd1: begin
				ph = 3'd0;
				if (c == 8'hd0)
					start(1'b1);
				else
					sr[5:4] = 2'b11;
			end
			3'd2: begin
				ph = 3'd0;
				start(1'b0);
			end
			3'd3: begin
				left = {1'b0, c[4:0]} + 6'd1;
				ph = 3'd4;
			end
			3'd4: begin
				left = left - 6'd1;
				if (left == 6'd0)
					ph = 3'd5;
			end
			3'd5: begin
				ph = 3'd0;
				start(1'b0);
			end
			default: if (c == 8'h70)
					mode = 2'd1;
				else if (c == 8'h50)
					sr = sr & 8'h44;
				else if (c == 8'hff)
					mode = 2'd0;
				else if (c == 8'hd0 && susp) begin
					susp = 1'b0;
					sr = sr & 8'hbb;
				end else if (c == 8'hb0) begin
					mode = 2'd1;
					if (busy > 0 && !susp) begin
						susp = 1'b1;
						sr[kind ? 6 : 2] = 1'b1;
					end
				end else if (!susp && c == 8'h20)
					ph = 3'd1;
				else if (!susp && c == 8'h40)
					ph = 3'd2;
				else if (!susp && c == 8'he8) begin
					mode = 2'd2;
					ph = 3'd3;
				end
			endcase
		end
		// Host drops select and data with the strobe, so keep the low-phase word
		if (!we_b_i && !chip_select_0_b_i)
			wd = dq_i;
		we_q = we_b_i;
		cs_q = chip_select_0_b_i;
		oe_q = oe_b_i | chip_select_0_b_i;
	end
endmodule

/* File: verif/tb_fcsl_host.sv */
// Self-checking bench for the flash host controller against a device model
`timescale 1ns/1ns
module tb_fcsl_host;
	reg clk_sys_i = 1'b0;
	reg rst_b_i = 1'b0;
	reg op_valid_i = 1'b0;
	reg [2:0] op_code_i = 3'h0;
	reg [22:0] op_addr_i = 23'h0;
	reg [15:0] op_data_i = 16'h0;
	reg [4:0] buf_count_i = 5'h1;
	reg buf_data_valid_i = 1'b0;
	reg [22:0] buf_addr_i = 23'h0;
	reg [15:0] buf_data_i = 16'h0;
	reg supply_low = 1'b0;
	reg block_locked = 1'b0;
	reg [31:0] rnd = 32'h2c4b3f2d;
	reg got_ref;
	integer n_fail = 0;
	integer total_checks = 0;
	integer i;
	wire op_ready_o, buf_data_ready_o, done_o, refused_o, ready_o, cs_b, oe_b, we_b, dq_oe, pin;
	wire err_seq, err_prog, err_erase, err_low, err_lock, erase_susp, prog_susp;
	wire [7:0] device_status_o, buffer_status_o;
	wire [22:0] addr;
	wire [15:0] dq_host, dq_dev;
	wire [15:0] dq_bus = dq_oe ? dq_host : dq_dev;
	wire [7:0] flags = {3'h0, err_seq, err_prog, err_erase, err_low, err_lock};
	fcsl_host uut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i),
		.op_ready_o(op_ready_o), .op_code_i(op_code_i), .op_addr_i(op_addr_i),
		.op_data_i(op_data_i), .buf_count_i(buf_count_i), .buf_data_ready_o(buf_data_ready_o),
		.buf_data_valid_i(buf_data_valid_i), .buf_addr_i(buf_addr_i), .buf_data_i(buf_data_i),
		.done_o(done_o), .device_status_o(device_status_o), .buffer_status_o(buffer_status_o),
		.err_sequence_o(err_seq), .err_program_o(err_prog), .err_erase_o(err_erase),
		.err_low_voltage_o(err_low), .err_locked_o(err_lock), .refused_o(refused_o),
		.erase_suspended_o(erase_susp), .program_suspended_o(prog_susp), .ready_o(ready_o),
		.chip_select_0_b_o(cs_b), .oe_b_o(oe_b), .we_b_o(we_b), .addr_o(addr), .dq_o(dq_host),
		.dq_oe_o(dq_oe), .dq_i(dq_bus), .status_output_pin_i(pin));
	fcsl_flash_model u_flash (.clk_sys_i(clk_sys_i), .chip_select_0_b_i(cs_b), .oe_b_i(oe_b),
		.we_b_i(we_b), .dq_i(dq_bus), .dq_o(dq_dev), .status_output_pin_o(pin),
		.supply_low_i(supply_low), .block_locked_i(block_locked));
	always #5 clk_sys_i = ~clk_sys_i;
	// Buffer words advance after each accepted word
	always @(posedge clk_sys_i) if (buf_data_ready_o && buf_data_valid_i) begin
		buf_data_i <= buf_data_i + 16'h1357;
		buf_addr_i <= buf_addr_i + 23'h1;
	end
	function [31:0] lfsr(input [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Expected status after a launch with supply and lock conditions
	function [7:0] exp_status(input low, input lock, input er);
		begin
			exp_status = 8'h80;
			if (low)
				exp_status = exp_status | (er ? 8'h28 : 8'h18);
			else if (lock)
				exp_status = exp_status | (er ? 8'h22 : 8'h12);
		end
	endfunction
	task chk(input [7:0] got, input [7:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// One user operation: request, hold until taken, wait for done
	task do_op(input [2:0] code, input [4:0] cnt);
		integer k;
		begin
			@(posedge clk_sys_i);
			rnd = lfsr(rnd);
			op_code_i <= code;
			op_addr_i <= rnd[22:0];
			op_data_i <= rnd[31:16];
			buf_count_i <= cnt;
			op_valid_i <= 1'b1;
			@(negedge clk_sys_i);
			while (op_ready_o !== 1'b1) @(negedge clk_sys_i);
			@(posedge clk_sys_i);
			op_valid_i <= 1'b0;
			k = 0;
			@(negedge clk_sys_i);
			while (done_o !== 1'b1 && k < 5000) begin
				k = k + 1;
				@(negedge clk_sys_i);
			end
			if (k == 5000)
				chk(8'h00, 8'hff);
			got_ref = refused_o;
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d, mismatches %0d", total_checks, n_fail);
			if (n_fail == 0 && total_checks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	initial begin
		#1000000;
		n_fail = n_fail + 1;
		print_verdict;
	end
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		buf_data_valid_i <= 1'b1;
		chk({4'h0, cs_b, oe_b, we_b, dq_oe}, 8'h0e);
		do_op(3'h0, 5'h1);
		chk(device_status_o, 8'h80);
		for (i = 0; i < 4; i = i + 1) begin
			do_op(3'h3, 5'h1);
			chk({7'h0, got_ref}, 8'h00);
			chk(device_status_o, exp_status(0, 0, 0));
			chk({7'h0, ready_o}, 8'h01);
			chk(addr[7:0], op_addr_i[7:0]);
		end
		do_op(3'h2, 5'h1);
		chk(device_status_o, exp_status(0, 0, 1));
		supply_low <= 1'b1;
		do_op(3'h3, 5'h1);
		chk(device_status_o, exp_status(1, 0, 0));
		chk(flags, 8'h0a);
		do_op(3'h0, 5'h1);
		chk(device_status_o, exp_status(1, 0, 0));
		do_op(3'h4, 5'h3);
		chk({7'h0, got_ref}, 8'h01);
		do_op(3'h1, 5'h1);
		chk(flags, 8'h00);
		supply_low <= 1'b0;
		block_locked <= 1'b1;
		do_op(3'h2, 5'h1);
		chk(device_status_o, exp_status(0, 1, 1));
		do_op(3'h1, 5'h1);
		do_op(3'h3, 5'h1);
		chk(device_status_o, exp_status(0, 1, 0));
		do_op(3'h1, 5'h1);
		block_locked <= 1'b0;
		do_op(3'h4, 5'h1f);
		chk({7'h0, got_ref}, 8'h00);
		chk(buffer_status_o, 8'h80);
		do_op(3'h4, rnd[4:0] | 5'h1);
		chk(device_status_o, 8'h80);
		do_op(3'h6, 5'h1);
		chk({7'h0, got_ref}, 8'h01);
		do_op(3'h5, 5'h1);
		chk({6'h0, erase_susp, prog_susp}, 8'h00);
		do_op(3'h7, 5'h1);
		chk({7'h0, got_ref}, 8'h00);
		print_verdict;
	end
endmodule
